//--- decim_timing_pkg.sv
// Package: constants for the decimation output-rate and settling control
package decim_timing_pkg;
  localparam int          RATE_WORD_W     = 10;           // Width of the rate divider word
  localparam int          MOD_CYCLES      = 1024;         // Master clocks per modulator frame
  localparam int          FRAME_W         = 10;           // Width of the frame counter
  localparam int          SINC4_ORDER     = 4;            // Periods per fourth-order settle
  localparam int          THIRD_ORDER_FILTER_SELECT_ORDER     = 3;            // Periods per third-order settle
  localparam int          CHOP_SETTLE     = 2;            // Conversions per settle with chop on
  localparam int          ZERO_LAT_BIT    = 11;           // Mode word bit enabling zero latency
  localparam int          MODE_W          = 24;           // Width of the mode control word
  localparam logic [9:0]  RATE_RESET      = 10'h060;      // Rate word after reset (96)
  localparam logic [9:0]  RATE_MAX        = 10'h3FF;      // Largest legal rate word (1023)
  localparam logic [2:0]  PHASE_RESET     = 3'h0;         // Phase counter after reset
  localparam logic [2:0]  SETTLE_RESET    = 3'h0;         // Settle counter after reset

  // Conversion sequencing states
  typedef enum logic [1:0] {
    ORDER_IDLE   = 2'b00,
    ORDER_SETTLE = 2'b01,
    ORDER_RUN    = 2'b10
  } conv_state_e;
endpackage

//--- rate_counter.sv
// Rate generator: counts master clocks, pulses at each programmed period
`timescale 1ns/1ns
`default_nettype none
module rate_counter #(
  parameter int WORD_W = 10
) (
  input  wire logic              clock_i,
  input  wire logic              rst_b_i,
  input  wire logic              restart_i,   // Filter reset restarts the count
  input  wire logic [WORD_W-1:0] divider_i,   // Frames of 1024 clocks per tick
  output logic                   tick_o       // One pulse per output sub-period
);
  import decim_timing_pkg::*;

  logic [FRAME_W-1:0] frame_cnt;              // Clocks inside one frame
  logic [WORD_W-1:0]  word_cnt;               // Frames inside one tick
  wire                frame_end = (frame_cnt == FRAME_W'(MOD_CYCLES - 1));
  wire                word_end  = (word_cnt >= divider_i - WORD_W'(1));

  // Nested counters; word compare uses >= so a shrinking divider cannot overrun
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || restart_i) begin
      frame_cnt <= '0;
      word_cnt  <= '0;
      tick_o    <= 1'b0;
    end else begin
      frame_cnt <= frame_cnt + FRAME_W'(1);
      tick_o    <= frame_end && word_end;     // RQ17
      if (frame_end) begin
        word_cnt <= word_end ? '0 : word_cnt + WORD_W'(1);
      end
    end
  end
endmodule
`default_nettype wire

//--- decim_timing.sv
// Decimation filter output timing: rate, settling, channel change, chop
//
// Summary of operation
// RQ1: Mode bit 11 enables zero latency
// RQ2: Zero latency: each conversion fully settles
// RQ3: Sinc4 zero latency period 4*1024*word clocks
// RQ4: Sinc4 word 480/80 give 10/60 Hz, quartered
// RQ5: Zero latency: unaligned step yields one unsettled
// RQ6: Third-order select bit picks third_order_filter_select filter
// RQ7: Third_order_filter_select period 1024*word; word 1..1023
// RQ8: Third_order_filter_select channel change: first result after three
// RQ9: Third_order_filter_select step settles third, mid-step fourth
// RQ10: Third_order_filter_select zero latency period 3*1024*word
// RQ11: Third_order_filter_select word 480 gives 10 or 3.3 Hz
// RQ12: Notch bit adds 60 Hz notch, rate unchanged
// RQ13: Chop swaps polarity, averages settled pairs
// RQ14: Sinc4 chop period 4*1024*word, settle two
// RQ15: Reset default sinc4 with chop off
// RQ16: Sinc4 channel change: first result after four
// RQ17: Rate generator strobes each period, restarts
`timescale 1ns/1ns
`default_nettype none
module decim_timing #(
  parameter int WORD_W = decim_timing_pkg::RATE_WORD_W
) (
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_b_i,
  input  wire logic [decim_timing_pkg::MODE_W-1:0]    mode_word_i,         // Mode control word
  input  wire logic [WORD_W-1:0]                      rate_divider_word_i, // Output rate word
  input  wire logic                                   third_order_filter_select_i,
  input  wire logic                                   sixty_hz_notch_enable_i,
  input  wire logic                                   chop_enable_i,       // Chop mode request
  input  wire logic                                   channel_change_i,    // One-cycle pulse
  input  wire logic                                   input_step_i,        // Step seen at input
  output logic                                        modulator_reset_o,   // Reset pulse to modulator
  output logic                                        filter_strobe_o,     // Conversion result ready
  output logic                                        result_settled_o,    // Result is fully settled
  output logic                                        chop_polarity_o,     // Current input orientation
  output logic                                        chop_average_o,      // Average with previous
  output logic                                        notch_60_o,          // Extra 60 Hz notch active
  output logic                                        third_order_o,       // Third_order_filter_select path active
  output logic [WORD_W-1:0]                           rate_word_o          // Word in effect
);
  import decim_timing_pkg::*;

  // Configuration held in flops so a mid-period write cannot tear a period
  logic              third_order_filter_select;                   // Filter order in effect
  logic              zero_lat;                // Zero latency in effect
  logic              chop;                    // Chop in effect
  logic [WORD_W-1:0] rate_word;               // Clamped rate word
  conv_state_e       state;                   // Conversion sequencing state
  conv_state_e       next_state;
  logic [2:0]        phase;                   // Sub-period index inside a conversion
  logic [2:0]        settle_cnt;              // Conversions since a step
  logic              step_pending;            // Step arrived, not yet counted
  logic              step_mid;                // Step arrived mid-conversion
  logic              tick;                    // Sub-period pulse from rate generator
  logic              restart;                 // Filter reset, restarts rate count

  // Decoded mode controls
  wire zl_req     = mode_word_i[ZERO_LAT_BIT];                        // RQ1
  wire word_zero  = (rate_divider_word_i == '0);
  // Host keeps the word in 1..1023; zero is forced to one so the counter never stalls
  wire [WORD_W-1:0] word_legal = word_zero ? WORD_W'(1) : rate_divider_word_i; // RQ7
  // Periods per conversion: zero latency and chop spread over the filter order
  wire [2:0] order      = third_order_filter_select ? 3'(THIRD_ORDER_FILTER_SELECT_ORDER) : 3'(SINC4_ORDER);
  wire [2:0] per_conv   = (zero_lat || chop) ? order : 3'd1;          // RQ3 RQ10 RQ14
  // Settling conversions after a channel change: two with chop, else the filter order
  wire [2:0] settle_len = chop ? 3'(CHOP_SETTLE) : order;            // RQ8 RQ16
  wire       last_phase = (phase == per_conv - 3'd1);
  wire       conv_done  = tick && last_phase;
  wire       reconfig   = (zl_req != zero_lat) || (third_order_filter_select_i != third_order_filter_select) ||
                          (chop_enable_i != chop) || (word_legal != rate_word);
  // Plain mode step settling count: order, plus one if the step was mid-conversion
  wire [2:0] step_need  = (zero_lat || chop) ? (step_mid ? 3'd2 : 3'd1)   // RQ5
                                             : (step_mid ? order + 3'd1 : order); // RQ9

  assign restart = channel_change_i || reconfig;

  rate_counter #(
    .WORD_W(WORD_W)
  ) u_rate (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b_i),
    .restart_i (restart),
    .divider_i (rate_word),
    .tick_o    (tick)
  );

  // Register configuration; defaults sinc4, chop off, zero latency off
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      third_order_filter_select     <= 1'b0;                      // RQ15
      zero_lat  <= 1'b0;
      chop      <= 1'b0;                      // RQ15
      rate_word <= RATE_RESET;
    end else begin
      third_order_filter_select     <= third_order_filter_select_i; // RQ6
      zero_lat  <= zl_req;                    // RQ1
      chop      <= chop_enable_i;
      rate_word <= word_legal;
    end
  end

  // Next-state selection for conversion sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      ORDER_IDLE: begin
        next_state = ORDER_SETTLE;
      end
      ORDER_SETTLE: begin
        // Plain mode waits out full settle; chop waits two full conversions
        if (conv_done && (zero_lat || settle_cnt == settle_len - 3'd1)) begin // RQ14
          next_state = ORDER_RUN;
        end
      end
      ORDER_RUN: begin
        next_state = ORDER_RUN;
      end
      default: begin
        next_state = ORDER_IDLE;
      end
    endcase
    if (restart) begin
      next_state = ORDER_IDLE;
    end
  end

  // Sub-period phase and sequencing state
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      state <= ORDER_IDLE;
      phase <= PHASE_RESET;
    end else begin
      state <= next_state;
      if (restart) begin
        phase <= PHASE_RESET;
      end else if (tick) begin
        phase <= last_phase ? PHASE_RESET : phase + 3'd1;
      end
    end
  end

  // Settling counters for channel change and input steps
  always_ff @(posedge clock_i) begin
    if (!rst_b_i || restart) begin
      settle_cnt   <= SETTLE_RESET;
      step_pending <= 1'b0;
      step_mid     <= 1'b0;
    end else begin
      if (state == ORDER_SETTLE && conv_done) begin
        settle_cnt <= settle_cnt + 3'd1;
      end else if (input_step_i) begin
        // Step restarts the settle count; mid-conversion if not at a boundary
        settle_cnt   <= SETTLE_RESET;
        step_pending <= 1'b1;
        step_mid     <= (phase != PHASE_RESET) || (state == ORDER_RUN && !conv_done);
      end else if (step_pending && conv_done) begin
        // Step wins over clear: a new step re-arms above
        settle_cnt   <= settle_cnt + 3'd1;
        step_pending <= (settle_cnt + 3'd1 < step_need);  // RQ9
      end
    end
  end

  // Result strobe, settled flag and chop orientation
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      filter_strobe_o   <= 1'b0;
      result_settled_o  <= 1'b0;
      chop_polarity_o   <= 1'b0;
      chop_average_o    <= 1'b0;
      modulator_reset_o <= 1'b0;
    end else begin
      modulator_reset_o <= restart;           // RQ8 RQ16
      // Zero latency emits every conversion; plain emits after first settle
      filter_strobe_o   <= conv_done && (state == ORDER_RUN ||
                           (state == ORDER_SETTLE && next_state == ORDER_RUN)); // RQ2
      // Settled flag only rides on a delivered result, never on a swallowed one
      result_settled_o  <= conv_done && (state == ORDER_RUN ||
                           (state == ORDER_SETTLE && next_state == ORDER_RUN)) &&
                           !(step_pending && settle_cnt + 3'd1 < step_need); // RQ5 RQ9
      if (restart || !chop) begin
        chop_polarity_o <= 1'b0;
        chop_average_o  <= 1'b0;
      end else if (conv_done) begin
        chop_polarity_o <= ~chop_polarity_o;  // RQ13
        chop_average_o  <= 1'b1;              // RQ13
      end
    end
  end

  // Mode status mirrors; notch changes response only, never the rate
  always_ff @(posedge clock_i) begin
    if (!rst_b_i) begin
      notch_60_o    <= 1'b0;
      third_order_o <= 1'b0;
      rate_word_o   <= RATE_RESET;
    end else begin
      notch_60_o    <= sixty_hz_notch_enable_i; // RQ12
      third_order_o <= third_order_filter_select;
      rate_word_o   <= rate_word;               // RQ4 RQ11
    end
  end
endmodule
`default_nettype wire

//--- decim_timing_assertions.sv
// Checker: port-level timing assertions for the decimation timing block
`timescale 1ns/1ns
`default_nettype none
module decim_timing_checker
  import decim_timing_pkg::*;
#(parameter int WORD_W = 10) (
  input wire logic                                clock_i,
  input wire logic                                rst_b_i,
  input wire logic [decim_timing_pkg::MODE_W-1:0] mode_word_i,
  input wire logic [WORD_W-1:0]                   rate_divider_word_i,
  input wire logic                                third_order_filter_select_i,
  input wire logic                                sixty_hz_notch_enable_i,
  input wire logic                                chop_enable_i,
  input wire logic                                channel_change_i,
  input wire logic                                input_step_i,
  input wire logic                                modulator_reset_o,
  input wire logic                                filter_strobe_o,
  input wire logic                                result_settled_o,
  input wire logic                                chop_polarity_o,
  input wire logic                                chop_average_o,
  input wire logic                                notch_60_o,
  input wire logic                                third_order_o,
  input wire logic [WORD_W-1:0]                   rate_word_o
);
  // One clock domain, so one default clocking and disable
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_chan; channel_change_i |=> modulator_reset_o; endproperty
  a_chan: assert property (p_chan) else $error("no restart on channel change");
  property p_cfg; ($changed(third_order_filter_select_i) || $changed(chop_enable_i)) |=> modulator_reset_o; endproperty
  a_cfg: assert property (p_cfg) else $error("no restart on filter change");
  property p_gap; filter_strobe_o |=> !filter_strobe_o [*8]; endproperty
  a_gap: assert property (p_gap) else $error("strobe too close");
  property p_set; result_settled_o |-> filter_strobe_o; endproperty
  a_set: assert property (p_set) else $error("settled without strobe");
  property p_quiet; modulator_reset_o |=> !filter_strobe_o [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("result right after restart");
  property p_dflt; $rose(rst_b_i) |-> !third_order_o && !chop_average_o && rate_word_o == RATE_RESET; endproperty
  a_dflt: assert property (p_dflt) else $error("bad reset defaults");
  property p_notch; sixty_hz_notch_enable_i ##1 sixty_hz_notch_enable_i |-> notch_60_o; endproperty
  a_notch: assert property (p_notch) else $error("notch not applied");
  property p_chop; !chop_enable_i [*3] |-> !chop_average_o; endproperty
  a_chop: assert property (p_chop) else $error("averaging without chop");
endmodule
bind decim_timing decim_timing_checker #(.WORD_W(WORD_W)) u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .mode_word_i(mode_word_i), .rate_divider_word_i(rate_divider_word_i), .chop_enable_i(chop_enable_i),
  .third_order_filter_select_i(third_order_filter_select_i), .sixty_hz_notch_enable_i(sixty_hz_notch_enable_i),
  .channel_change_i(channel_change_i), .input_step_i(input_step_i), .modulator_reset_o(modulator_reset_o),
  .filter_strobe_o(filter_strobe_o), .result_settled_o(result_settled_o), .chop_polarity_o(chop_polarity_o),
  .chop_average_o(chop_average_o), .notch_60_o(notch_60_o), .third_order_o(third_order_o),
  .rate_word_o(rate_word_o));
`default_nettype wire

//--- host_model.sv
// Host model: collects results, measures pacing and first-result delay
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clock_i,
  input wire logic strobe_i,   // Result ready
  input wire logic settled_i,  // Result settled
  input wire logic restart_i,  // Modulator restart
  output int       strobes_o,  // Results taken
  output int       settled_o,  // Settled results taken
  output int       gap_o,      // Clocks between last two results
  output int       first_o     // Clocks from restart to first result
);
  int   since_strobe;  // Clocks since last result
  int   since_restart; // Clocks since last restart
  logic waiting = 1'b0; // First result still pending
  // Host reads every result, so pacing is seen exactly
  always_ff @(posedge clock_i) begin
    since_strobe  <= since_strobe + 1;
    since_restart <= restart_i ? 1 : since_restart + 1;
    if (restart_i) waiting <= 1'b1;
    if (strobe_i) begin
      strobes_o    <= strobes_o + 1;
      gap_o        <= since_strobe;
      since_strobe <= 1;
      settled_o    <= settled_o + int'(settled_i);
      if (waiting && !restart_i) begin
        first_o <= since_restart;
        waiting <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

//--- decim_timing_test.sv
// Testbench: output pacing and settling of the decimation timing block
`timescale 1ns/1ns
`default_nettype none
module decim_timing_test;
  import decim_timing_pkg::*;
  logic              clock_i = 1'b0;   // Master clock
  logic              rst_b_i = 1'b0;   // Held low at start
  logic [MODE_W-1:0] mode    = '0;     // Mode word
  logic [9:0]        word    = 10'h001; // Rate word
  logic              s3 = 0, notch = 0, chop = 0, chg = 0, step = 0;
  wire               mr, strobe, settled, pol, avg, n60, t3;
  wire  [9:0]        rate_o;
  int                mismatches, check_count, cycles, strobes, settled_n, gap, first, s0;
  decim_timing #(.WORD_W(10)) u_decim_timing (.clock_i(clock_i), .rst_b_i(rst_b_i), .mode_word_i(mode),
    .rate_divider_word_i(word), .third_order_filter_select_i(s3), .sixty_hz_notch_enable_i(notch),
    .chop_enable_i(chop), .channel_change_i(chg), .input_step_i(step), .modulator_reset_o(mr),
    .filter_strobe_o(strobe), .result_settled_o(settled), .chop_polarity_o(pol), .chop_average_o(avg),
    .notch_60_o(n60), .third_order_o(t3), .rate_word_o(rate_o));
  host_model u_host_model (.clock_i(clock_i), .strobe_i(strobe), .settled_i(settled), .restart_i(mr),
    .strobes_o(strobes), .settled_o(settled_n), .gap_o(gap), .first_o(first));
  initial forever #5 clock_i = ~clock_i;
  // Hang guard, sized a little above the full run
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 99000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("mismatches %0d checks %0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_res(input int n);
    int target;
    target = strobes + n;
    while (strobes < target) @(negedge clock_i);
  endtask
  // Configure, change channel, take n results; word kept in 1..1023
  task automatic run(input logic zl, input logic t, input logic c, input logic nt, input logic [9:0] w, input int n);
    @(negedge clock_i);
    mode[ZERO_LAT_BIT] = zl;
    s3 = t;
    chop = c;
    notch = nt;
    word = w;
    repeat (2) @(negedge clock_i);
    chg = 1'b1;
    @(negedge clock_i) chg = 1'b0;
    s0 = settled_n;
    wait_res(n);
  endtask
  // First result lands a couple of clocks after the settle time
  task automatic chk_first(input int e);
    check(first >= e && first <= e + 3, 1'b1);
  endtask
  task automatic step_mid(input int d);
    wait_res(1);
    repeat (d) @(negedge clock_i);
    step = 1'b1;
    @(negedge clock_i) step = 1'b0;
    s0 = settled_n;
  endtask
  task automatic t_plain4;
    run(0, 0, 0, 0, 10'h001, 3);
    check(gap, 1024);
    chk_first(4096);
    run(0, 0, 0, 1, 10'h001, 2);
    check(n60, 1'b1);
    check(gap, 1024);
  endtask
  task automatic t_zl4;
    run(1, 0, 0, 0, 10'h001, 2);
    check(gap, 4096);
    check(settled_n - s0, 2);
    step_mid(1000);
    wait_res(3);
    check(settled_n - s0, 2);
  endtask
  task automatic t_s3;
    run(0, 1, 0, 0, 10'h002, 2);
    check(t3, 1'b1);
    check(gap, 2048);
    chk_first(6144);
    step_mid(500);
    wait_res(3);
    check(settled_n - s0, 0);
    wait_res(1);
    check(settled_n - s0, 1);
  endtask
  task automatic t_zl3_words;
    run(1, 1, 0, 0, 10'h001, 2);
    check(gap, 3072);
    chk_first(3072);
    run(1, 1, 0, 0, 10'h1E0, 0);
    check(rate_o, 10'h1E0);
    run(0, 0, 0, 0, 10'h050, 0);
    check(rate_o, 10'h050);
  endtask
  task automatic t_chop;
    logic p0;
    run(0, 0, 1, 0, 10'h001, 2);
    check(gap, 4096);
    chk_first(8192);
    p0 = pol;
    wait_res(1);
    check(pol, !p0);
    check(avg, 1'b1);
  endtask
  initial begin
    repeat (8) @(negedge clock_i);
    check(t3, 1'b0);
    check(rate_o, RATE_RESET);
    rst_b_i = 1'b1;
    t_plain4();
    t_zl4();
    t_s3();
    t_zl3_words();
    t_chop();
    summarize();
  end
endmodule
`default_nettype wire
